// *** rtl/rqa_pkg.sv ***
package rqa_pkg;

	// master ports, listed in static order: lowest id wins a tie
	localparam int NUM_MASTERS  = 5;
	localparam int ID_W         = 3;
	localparam int DATA_W       = 32;
	localparam int RAM_ADDR_W   = 13;
	localparam int QOS_W        = 2;
	localparam int QOS_LSB      = 0;
	localparam int QOS_MSB      = QOS_LSB + QOS_W - 1;

	localparam logic [ID_W-1:0] PORT_CPU   = 3'h0;
	localparam logic [ID_W-1:0] PORT_DMA   = 3'h1;
	localparam logic [ID_W-1:0] PORT_CAN   = 3'h2;
	localparam logic [ID_W-1:0] PORT_TRACE = 3'h3;
	localparam logic [ID_W-1:0] PORT_DEBUG = 3'h4;

	// service priority levels, a higher code ranks higher
	typedef logic [QOS_W-1:0] rqa_level_t;
	localparam rqa_level_t QOS_BACKGROUND = 2'h0;
	localparam rqa_level_t QOS_BANDWIDTH  = 2'h1;
	localparam rqa_level_t QOS_LATENCY    = 2'h2;
	localparam rqa_level_t QOS_CRITICAL   = 2'h3;

	localparam rqa_level_t TRACE_LEVEL     = QOS_CRITICAL;
	localparam rqa_level_t DEBUG_LEVEL     = QOS_BANDWIDTH;
	localparam rqa_level_t CPU_LEVEL_RESET = QOS_BACKGROUND;

	// register byte addresses on the APB
	localparam logic [31:0] CPU_LEVEL_ADDR = 32'h41007110;
	localparam logic [31:0] STATUS_ADDR    = 32'h41007114;

	// status word layout
	localparam int STAT_PEND_LSB = 0;
	localparam int STAT_LAST_LSB = 8;

	typedef struct packed {
		logic                  valid;
		logic                  write;
		logic [RAM_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]     wdata;
	} rqa_req_t;

	typedef struct packed {
		logic                  en;
		logic                  write;
		logic [RAM_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]     wdata;
	} rqa_ram_cmd_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [31:0]       paddr;
		logic [DATA_W-1:0] pwdata;
	} rqa_apb_req_t;

	typedef struct packed {
		logic              pready;
		logic [DATA_W-1:0] prdata;
		logic              pslverr;
	} rqa_apb_rsp_t;

	typedef struct packed {
		rqa_apb_rsp_t rsp;
		rqa_level_t   cpu_level;
	} rqa_apb_state_t;

	typedef struct packed {
		logic [NUM_MASTERS-1:0] grant;
		logic [NUM_MASTERS-1:0] waited;
		rqa_ram_cmd_t           cmd;
		logic                   rd_pend;
		logic [ID_W-1:0]        rd_id;
		logic [NUM_MASTERS-1:0] rsp_valid;
		logic [DATA_W-1:0]      rdata;
		logic [ID_W-1:0]        last_id;
	} rqa_arb_state_t;

endpackage : rqa_pkg

// *** rtl/rqa_pick.sv ***
`timescale 1ns/100ps
`default_nettype none
module rqa_pick import rqa_pkg::*; (
	// candidates
	input  wire logic [NUM_MASTERS-1:0]        eligible,
	input  wire rqa_level_t [NUM_MASTERS-1:0]  level,
	// winner
	output logic                               win_valid,
	output logic [ID_W-1:0]                    win_id,
	output logic [NUM_MASTERS-1:0]             win_onehot
);

	// strict greater keeps the earlier, lower id on a tie
	function automatic logic beats(input rqa_level_t a, input rqa_level_t b);
		beats = a > b;
	endfunction : beats

	always_comb begin
		win_valid  = 1'b0;
		win_id     = '0;
		win_onehot = '0;
		for (int i = 0; i < NUM_MASTERS; i++) begin
			if (eligible[i] && (!win_valid || beats(level[i], level[win_id]))) begin
				win_valid = 1'b1;
				win_id    = ID_W'(i);
			end
		end
		if (win_valid) begin
			win_onehot[win_id] = 1'b1;
		end
	end

endmodule : rqa_pick
`default_nettype wire

// *** rtl/rqa_apb_reg.sv ***
`timescale 1ns/100ps
`default_nettype none
module rqa_apb_reg import rqa_pkg::*; (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// apb
	input  wire rqa_apb_req_t apb_req,
	output rqa_apb_rsp_t      apb_rsp,
	// block side
	input  wire logic [31:0]  status,
	output rqa_level_t        cpu_level
);

	rqa_apb_state_t st;
	rqa_apb_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.rsp.pready  = 1'b0;
		next_st.rsp.pslverr = 1'b0;
		next_st.rsp.prdata  = '0;
		// answer prepared in setup, shown in the first access cycle
		if (apb_req.psel && !apb_req.penable) begin
			next_st.rsp.pready = 1'b1;
			if (apb_req.paddr == CPU_LEVEL_ADDR) begin
				next_st.rsp.prdata = DATA_W'(st.cpu_level);
			end else if (apb_req.paddr == STATUS_ADDR) begin
				next_st.rsp.prdata = status;
			end else begin
				next_st.rsp.pslverr = 1'b1;
			end
		end
		if (apb_req.psel && apb_req.penable && st.rsp.pready && apb_req.pwrite
				&& apb_req.paddr == CPU_LEVEL_ADDR) begin
			next_st.cpu_level = apb_req.pwdata[QOS_MSB:QOS_LSB];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{rsp: '0, cpu_level: CPU_LEVEL_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign apb_rsp   = st.rsp;
	assign cpu_level = st.cpu_level;

endmodule : rqa_apb_reg
`default_nettype wire

// *** rtl/ram_qos_arbiter.sv ***
`timescale 1ns/100ps
`default_nettype none
module ram_qos_arbiter import rqa_pkg::*; (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire rqa_apb_req_t             apb_req,
	output rqa_apb_rsp_t                  apb_rsp,
	// master requests, indexed by port id
	input  wire rqa_req_t [NUM_MASTERS-1:0] req,
	input  wire rqa_level_t               dma_level,
	input  wire rqa_level_t               can_level,
	// master answers
	output logic [NUM_MASTERS-1:0]        grant,
	output logic [NUM_MASTERS-1:0]        rsp_valid,
	output logic [DATA_W-1:0]             rdata,
	// ram
	output rqa_ram_cmd_t                  ram_cmd,
	input  wire logic [DATA_W-1:0]        ram_rdata
);

	rqa_arb_state_t             st;
	rqa_arb_state_t             next_st;
	rqa_level_t                 cpu_level;
	rqa_level_t [NUM_MASTERS-1:0] level;
	logic [NUM_MASTERS-1:0]     live;
	logic [NUM_MASTERS-1:0]     eligible;
	logic                       win_valid;
	logic [ID_W-1:0]            win_id;
	logic [NUM_MASTERS-1:0]     win_onehot;
	logic [31:0]                status;

	function automatic logic needs_wait(input rqa_level_t lvl);
		needs_wait = lvl < QOS_LATENCY;
	endfunction : needs_wait

	rqa_apb_reg u_regs (
		.pclk      (pclk),
		.presetn   (presetn),
		.apb_req   (apb_req),
		.apb_rsp   (apb_rsp),
		.status    (status),
		.cpu_level (cpu_level)
	);

	always_comb begin
		level             = '0;
		level[PORT_CPU]   = cpu_level;
		level[PORT_DMA]   = dma_level;
		level[PORT_CAN]   = can_level;
		level[PORT_TRACE] = TRACE_LEVEL;
		level[PORT_DEBUG] = DEBUG_LEVEL;
	end

	always_comb begin
		live     = '0;
		eligible = '0;
		for (int i = 0; i < NUM_MASTERS; i++) begin
			// a request seen while its grant shows is the one just served
			live[i]     = req[i].valid && !st.grant[i];
			eligible[i] = live[i] && (!needs_wait(level[i]) || st.waited[i]);
		end
	end

	rqa_pick u_pick (
		.eligible   (eligible),
		.level      (level),
		.win_valid  (win_valid),
		.win_id     (win_id),
		.win_onehot (win_onehot)
	);

	always_comb begin
		status = '0;
		status[STAT_PEND_LSB +: NUM_MASTERS] = live;
		status[STAT_LAST_LSB +: ID_W]        = st.last_id;
	end

	always_comb begin
		next_st        = st;
		next_st.grant  = win_onehot;
		next_st.waited = live & ~win_onehot;
		next_st.cmd    = '0;
		// a read command standing now has its ram data one cycle later
		next_st.rd_pend = st.cmd.en && !st.cmd.write;
		next_st.rd_id   = st.last_id;
		if (win_valid) begin
			next_st.cmd.en    = 1'b1;
			next_st.cmd.write = req[win_id].write;
			next_st.cmd.addr  = req[win_id].addr;
			next_st.cmd.wdata = req[win_id].wdata;
			next_st.last_id   = win_id;
		end
		// ram read data stand the cycle after the command, taken at its end
		next_st.rsp_valid = '0;
		if (st.rd_pend) begin
			next_st.rsp_valid[st.rd_id] = 1'b1;
			next_st.rdata               = ram_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign grant     = st.grant;
	assign rsp_valid = st.rsp_valid;
	assign rdata     = st.rdata;
	assign ram_cmd   = st.cmd;

endmodule : ram_qos_arbiter
`default_nettype wire

// *** tb/rqa_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module rqa_chk import rqa_pkg::*; (
	// clock and reset
	input wire logic                       pclk,
	input wire logic                       presetn,
	// watched ports
	input wire rqa_apb_req_t               apb_req,
	input wire rqa_apb_rsp_t               apb_rsp,
	input wire rqa_req_t [NUM_MASTERS-1:0] req,
	input wire logic [NUM_MASTERS-1:0]     grant,
	input wire logic [NUM_MASTERS-1:0]     rsp_valid,
	input wire logic [DATA_W-1:0]          rdata,
	input wire rqa_ram_cmd_t               ram_cmd,
	input wire logic [DATA_W-1:0]          ram_rdata
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_one_grant: assert property ($onehot0(grant)) else $error("two grants");
	chk_grant_cmd: assert property (grant != 0 |-> ram_cmd.en) else $error("no ram cmd");
	chk_debug_wait: assert property ($rose(req[4].valid) |=> !grant[4])
		else $error("debug served at once");
	chk_trace_fast: assert property ($rose(req[3].valid) && !req[0].valid && !req[1].valid
		&& !req[2].valid |=> grant[3]) else $error("trace late");
	chk_apb_ready: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("pready late");
	chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("long pready");
	chk_read_path: assert property (ram_cmd.en && !ram_cmd.write |-> ##2
		rsp_valid == $past(grant, 2) && rdata == $past(ram_rdata)) else $error("bad read");
	chk_slave_err: assert property (apb_rsp.pready |-> apb_rsp.pslverr ==
		(apb_req.paddr != CPU_LEVEL_ADDR && apb_req.paddr != STATUS_ADDR)) else $error("pslverr");
endmodule : rqa_chk
`default_nettype wire

// *** tb/rqa_ram_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rqa_ram_model import rqa_pkg::*; (
	// clock
	input wire logic          pclk,
	// ram side
	input wire rqa_ram_cmd_t  ram_cmd,
	output logic [DATA_W-1:0] ram_rdata
);
	initial ram_rdata = 32'h0;
	// outside a read the word flips each cycle, so stale data matches the last read word only every other cycle
	always @(posedge pclk) begin
		ram_rdata <= (ram_cmd.en && !ram_cmd.write) ? {19'h0, ram_cmd.addr} ^ 32'hA5C3 : ~ram_rdata;
	end
endmodule : rqa_ram_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top import rqa_pkg::*;;
	logic                       pclk, presetn, err;
	rqa_apb_req_t               apb_req;
	rqa_apb_rsp_t               apb_rsp;
	rqa_req_t [NUM_MASTERS-1:0] req;
	rqa_level_t                 dma_level, can_level, cpu_lv;
	logic [NUM_MASTERS-1:0]     grant, rsp_valid, pend;
	logic [DATA_W-1:0]          rdata, ram_rdata, rd;
	rqa_ram_cmd_t               ram_cmd;
	int                         fail_count, cmp_count, cyc, last_g;

	ram_qos_arbiter i_ram_qos_arbiter(.pclk, .presetn, .apb_req, .apb_rsp, .req, .dma_level,
		.can_level, .grant, .rsp_valid, .rdata, .ram_cmd, .ram_rdata);
	rqa_ram_model i_rqa_ram_model(.pclk, .ram_cmd, .ram_rdata);

	function automatic rqa_level_t lv(int i);
		case (i)
			0: return cpu_lv;
			1: return dma_level;
			2: return can_level;
			3: return TRACE_LEVEL;
			default: return DEBUG_LEVEL;
		endcase
	endfunction : lv

	// strict compare keeps the lowest id on a tie
	function automatic int best(logic [NUM_MASTERS-1:0] p);
		int b;
		b = -1;
		for (int i = 0; i < NUM_MASTERS; i++)
			if (p[i] && (b < 0 || lv(i) > lv(b))) b = i;
		return b;
	endfunction : best

	task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : apb

	task automatic round(logic [NUM_MASTERS-1:0] mask);
		@(posedge pclk);
		dma_level <= 2'($urandom);
		can_level <= 2'($urandom);
		for (int i = 0; i < NUM_MASTERS; i++)
			if (mask[i]) req[i] <= '{1'b1, 1'($urandom), 13'($urandom), $urandom};
		pend = mask;
		while (pend != 0) begin
			@(posedge pclk);
			if (grant != 0) begin
				`CHK("grant", NUM_MASTERS'(1 << best(pend)), grant)
				for (int i = 0; i < NUM_MASTERS; i++)
					if (grant[i]) begin
						req[i].valid <= 1'b0;
						pend[i] = 1'b0;
						last_g = i;
					end
			end
		end
	endtask : round

	task final_report();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		apb_req = '0;
		req = '0;
		dma_level = '0;
		can_level = '0;
		cpu_lv = '0;
		presetn = 1'b0;
		void'($urandom(20));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CPU_LEVEL_ADDR, '0);
		`CHK("cpu level reset", 32'h0, rd)
		apb(1'b1, 32'h41007118, 32'hFFFFFFFF);
		`CHK("unmapped", 1'b1, err)
		round(5'h08);
		round(5'h10);
		repeat (30) begin
			cpu_lv = 2'($urandom);
			apb(1'b1, CPU_LEVEL_ADDR, {30'($urandom), cpu_lv});
			apb(1'b0, CPU_LEVEL_ADDR, '0);
			`CHK("cpu level", {30'h0, cpu_lv}, rd)
			round(5'($urandom) | 5'h01);
		end
		round(5'h1F);
		apb(1'b1, STATUS_ADDR, 32'hFFFFFFFF);
		apb(1'b0, STATUS_ADDR, '0);
		`CHK("status", {21'h0, 3'(last_g), 8'h0}, rd)
		final_report();
	end
endmodule : tb_top
bind ram_qos_arbiter rqa_chk i_rqa_chk(.pclk, .presetn, .apb_req, .apb_rsp, .req, .grant,
	.rsp_valid, .rdata, .ram_cmd, .ram_rdata);
`default_nettype wire
